// ===== hdl/tsoc_pkg.sv
package tsoc_pkg;
	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 8;
	localparam int IRQ_W = 7;
	localparam int NCHAN = 2;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CHAN1_STAT = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CHANX_STAT = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CHAN1_CMPA = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CHAN1_CMPB = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_CHANX_CMPA = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_CHANX_CMPB = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h20;
	// status and control register field positions
	localparam int BIT_MATCH_B = 7;
	localparam int BIT_MATCH_A = 6;
	localparam int BIT_WRAP = 5;
	localparam int BIT_MID = 4;
	localparam int BIT_OSB_LO = 2;
	localparam int BIT_OSA_LO = 0;
	localparam int BIT_CIE = 0;
	// interrupt status bit positions
	localparam int IRQ_C1_B = 0;
	localparam int IRQ_C1_A = 1;
	localparam int IRQ_C1_W = 2;
	localparam int IRQ_CX_B = 3;
	localparam int IRQ_CX_A = 4;
	localparam int IRQ_CX_W = 5;
	localparam int IRQ_CAP = 6;
	// reset values and counter corners
	localparam logic [CNT_W-1:0] CMP_RESET = 8'hff;
	localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic CIE_RESET = 1'b1;
	localparam logic RSVD_READ = 1'b1;
	localparam logic [IRQ_W-1:0] IRQ_ZERO = 7'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
	// output action on a compare match
	typedef enum logic [1:0] {
		OS_KEEP = 2'b00,
		OS_LOW = 2'b01,
		OS_HIGH = 2'b10,
		OS_TOGGLE = 2'b11
	} tsoc_out_sel_e;
	// capture edge sequencer, gray along the path
	typedef enum logic {
		CAP_WAIT_RISE = 1'b0,
		CAP_WAIT_FALL = 1'b1
	} tsoc_cap_e;
	// per-channel flags and output selects
	typedef struct packed {
		logic match_b_flag;
		logic match_a_flag;
		logic wrap_flag;
		tsoc_out_sel_e out_sel_b;
		tsoc_out_sel_e out_sel_a;
	} tsoc_chan_s;
	// read-then-write-zero arming for flag bits 7..4
	typedef struct packed {
		logic b;
		logic a;
		logic w;
		logic mid;
	} tsoc_arm_s;
	localparam tsoc_chan_s CHAN_RESET = '{1'b0, 1'b0, 1'b0, OS_KEEP,
		OS_KEEP};
	localparam tsoc_arm_s ARM_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};
endpackage : tsoc_pkg

// ===== hdl/tsoc_top.sv
// Functional notes
// R1 - compare-B match sets flag bit 7
// R2 - compare-A match sets flag bit 6
// R3 - counter wrap ff to 00 sets bit 5
// R4 - clear needs read at 1, then write 0
// R5 - writing 1 to a flag does nothing
// R6 - channel 1 bit 4 reads 1, ignores writes
// R7 - compare-B drives pin per bits 3:2
// R8 - compare-A drives pin per bits 1:0
// R9 - capture flag after rise then fall
// R10 - capture flag clears by read then zero-write
// R11 - capture request only when flag and enable
// R12 - flag set beats simultaneous clear
`timescale 1ns/1ps
`default_nettype none
module tsoc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tsoc_pkg::ADDR_W-1:0] paddr,
	input wire logic [tsoc_pkg::DATA_W-1:0] pwdata,
	output logic [tsoc_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [tsoc_pkg::CNT_W-1:0] chan1_counter,
	input wire logic [tsoc_pkg::CNT_W-1:0] chanx_counter,
	input wire logic capture_reset_in,
	output logic chan1_timer_out_pin,
	output logic chanx_timer_out_pin,
	output logic capture_irq_request,
	output logic irq
);
	import tsoc_pkg::*;

	// pin level after a match, per select code
	function automatic logic out_action(input logic ev,
		input tsoc_out_sel_e sel, input logic cur);
		logic res;
		res = cur;
		if (ev) begin
			case (sel)
				OS_KEEP: res = cur;
				OS_LOW: res = 1'b0;
				OS_HIGH: res = 1'b1;
				OS_TOGGLE: res = ~cur;
				default: res = cur;
			endcase
		end
		return res;
	endfunction : out_action

	// status byte image seen by software
	function automatic logic [CNT_W-1:0] status_byte(input tsoc_chan_s c,
		input logic mid);
		logic [CNT_W-1:0] v;
		v = {c.match_b_flag, c.match_a_flag, c.wrap_flag, mid,
			c.out_sel_b, c.out_sel_a};
		return v;
	endfunction : status_byte

	// flag update: armed zero-write clears, event sets last
	function automatic logic flag_next(input logic cur, input logic wr,
		input logic wbit, input logic armed, input logic ev);
		logic res;
		res = cur;
		if (wr && !wbit && armed) begin
			res = 1'b0; // R4 R5 R10
		end
		if (ev) begin
			res = 1'b1; // R12
		end
		return res;
	endfunction : flag_next

	// registered state
	// channel flags and output selects
	tsoc_chan_s chan_ff [NCHAN];
	tsoc_chan_s nxt_chan [NCHAN];
	// clear arming per flag bit
	tsoc_arm_s arm_ff [NCHAN];
	tsoc_arm_s nxt_arm [NCHAN];
	// compare values, all ones after reset
	logic [CNT_W-1:0] cmp_a_ff [NCHAN];
	logic [CNT_W-1:0] nxt_cmp_a [NCHAN];
	logic [CNT_W-1:0] cmp_b_ff [NCHAN];
	logic [CNT_W-1:0] nxt_cmp_b [NCHAN];
	// previous counter sample, for change and wrap detection
	logic [CNT_W-1:0] prev_ff [NCHAN];
	logic [CNT_W-1:0] nxt_prev [NCHAN];
	// timer output pin levels
	logic pin_ff [NCHAN];
	logic nxt_pin [NCHAN];
	logic icf_ff; // capture done flag
	logic nxt_icf;
	logic cie_ff; // capture interrupt enable
	logic nxt_cie;
	// capture edge sequencer
	tsoc_cap_e cap_ff;
	tsoc_cap_e nxt_cap;
	logic cap_in_prev_ff; // last sample of reset input
	logic nxt_cap_in_prev;
	logic [IRQ_W-1:0] ists_ff; // sticky interrupt status
	logic [IRQ_W-1:0] nxt_ists;
	logic [IRQ_W-1:0] imask_ff; // interrupt mask
	logic [IRQ_W-1:0] nxt_imask;
	// apb read data and error, loaded in setup
	logic [DATA_W-1:0] prdata_ff;
	logic [DATA_W-1:0] nxt_prdata;
	logic pslverr_ff;
	logic nxt_pslverr;

	// combinational helpers
	// counter view per channel index
	logic [CNT_W-1:0] cnt [NCHAN];
	logic [ADDR_W-1:0] stat_off [NCHAN];
	logic [ADDR_W-1:0] cmpa_off [NCHAN];
	logic [ADDR_W-1:0] cmpb_off [NCHAN];
	// events seen this cycle
	logic ev_b [NCHAN];
	logic ev_a [NCHAN];
	logic ev_w [NCHAN];
	logic ev_cap;

	// index 0 is channel 1, index 1 is channel x
	assign cnt[0] = chan1_counter;
	assign cnt[1] = chanx_counter;
	// per-channel register offsets
	assign stat_off[0] = OFF_CHAN1_STAT;
	assign stat_off[1] = OFF_CHANX_STAT;
	assign cmpa_off[0] = OFF_CHAN1_CMPA;
	assign cmpa_off[1] = OFF_CHANX_CMPA;
	assign cmpb_off[0] = OFF_CHAN1_CMPB;
	assign cmpb_off[1] = OFF_CHANX_CMPB;

	// outputs
	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff;
	assign pready = 1'b1; // zero-wait slave
	assign chan1_timer_out_pin = pin_ff[0];
	assign chanx_timer_out_pin = pin_ff[1];
	assign capture_irq_request = icf_ff & cie_ff; // R11
	// level interrupt while an unmasked sticky bit is set
	assign irq = |(ists_ff & imask_ff);

	// match and wrap events, only on a counter change
	always_comb begin
		for (int i = 0; i < NCHAN; i++) begin
			ev_b[i] = (cnt[i] != prev_ff[i]) && (cnt[i] == cmp_b_ff[i]); // R1
			ev_a[i] = (cnt[i] != prev_ff[i]) && (cnt[i] == cmp_a_ff[i]); // R2
			ev_w[i] = (prev_ff[i] == CNT_MAX) && (cnt[i] == CNT_ZERO); // R3
		end
	end

	// capture sequencer: rise then fall in order
	always_comb begin
		nxt_cap = cap_ff;
		ev_cap = 1'b0;
		nxt_cap_in_prev = capture_reset_in;
		case (cap_ff)
			// idle: wait for a rising edge
			CAP_WAIT_RISE: begin
				if (capture_reset_in && !cap_in_prev_ff) begin
					nxt_cap = CAP_WAIT_FALL; // R9
				end
			end
			// armed: a falling edge completes the capture
			CAP_WAIT_FALL: begin
				if (!capture_reset_in && cap_in_prev_ff) begin
					nxt_cap = CAP_WAIT_RISE;
					ev_cap = 1'b1; // R9
				end
			end
			// unused code falls back to idle
			default: nxt_cap = CAP_WAIT_RISE;
		endcase
	end

	// register file, flags, pins and interrupt status
	always_comb begin
		logic setup;
		logic wr;
		logic rd;
		logic hit;
		logic [IRQ_W-1:0] ev_vec;
		// apb phase decode
		setup = psel && !penable;
		wr = psel && penable && pwrite;
		rd = psel && penable && !pwrite;
		hit = 1'b0;
		// events in irq status bit order
		ev_vec = {ev_cap, ev_w[1], ev_a[1], ev_b[1], ev_w[0], ev_a[0],
			ev_b[0]};
		// prev_ff samples the counter; the rest hold unless a branch below moves it
		nxt_icf = icf_ff;
		nxt_cie = cie_ff;
		nxt_ists = ists_ff;
		nxt_imask = imask_ff;
		nxt_prdata = prdata_ff;
		nxt_pslverr = pslverr_ff;
		for (int i = 0; i < NCHAN; i++) begin
			nxt_chan[i] = chan_ff[i];
			nxt_arm[i] = arm_ff[i];
			nxt_cmp_a[i] = cmp_a_ff[i];
			nxt_cmp_b[i] = cmp_b_ff[i];
			nxt_prev[i] = cnt[i];
			nxt_pin[i] = pin_ff[i];
		end
		// setup phase: capture read data and decode error
		if (setup) begin
			nxt_prdata = DATA_ZERO;
			case (paddr)
				OFF_CHAN1_STAT: begin
					nxt_prdata[CNT_W-1:0] = status_byte(chan_ff[0],
						RSVD_READ); // R6
					hit = 1'b1;
				end
				OFF_CHANX_STAT: begin
					nxt_prdata[CNT_W-1:0] = status_byte(chan_ff[1], icf_ff);
					hit = 1'b1;
				end
				OFF_CHAN1_CMPA, OFF_CHANX_CMPA: begin
					nxt_prdata[CNT_W-1:0] = (paddr == OFF_CHAN1_CMPA) ?
						cmp_a_ff[0] : cmp_a_ff[1];
					hit = 1'b1;
				end
				OFF_CHAN1_CMPB, OFF_CHANX_CMPB: begin
					nxt_prdata[CNT_W-1:0] = (paddr == OFF_CHAN1_CMPB) ?
						cmp_b_ff[0] : cmp_b_ff[1];
					hit = 1'b1;
				end
				OFF_CTRL: begin
					nxt_prdata[BIT_CIE] = cie_ff;
					hit = 1'b1;
				end
				OFF_IRQ_STAT: begin
					nxt_prdata[IRQ_W-1:0] = ists_ff;
					hit = 1'b1;
				end
				OFF_IRQ_MASK: begin
					nxt_prdata[IRQ_W-1:0] = imask_ff;
					hit = 1'b1;
				end
				default: hit = 1'b0; // unmapped reads zero
			endcase
			nxt_pslverr = !hit;
		end
		// per-channel status, compare and pin
		for (int i = 0; i < NCHAN; i++) begin
			logic wsel;
			wsel = wr && (paddr == stat_off[i]);
			// read while set arms the clear
			if (rd && (paddr == stat_off[i])) begin
				nxt_arm[i].b = prdata_ff[BIT_MATCH_B]; // R4
				nxt_arm[i].a = prdata_ff[BIT_MATCH_A]; // R4
				nxt_arm[i].w = prdata_ff[BIT_WRAP]; // R4
				nxt_arm[i].mid = (i == 1) && prdata_ff[BIT_MID]; // R10
			end
			// write: selects load, arming ends
			if (wsel) begin
				nxt_chan[i].out_sel_b = tsoc_out_sel_e'(
					pwdata[BIT_OSB_LO +: 2]);
				nxt_chan[i].out_sel_a = tsoc_out_sel_e'(
					pwdata[BIT_OSA_LO +: 2]);
				nxt_arm[i] = ARM_RESET; // a write ends the arming
			end
			// flags: armed zero clears, event sets
			nxt_chan[i].match_b_flag = flag_next(chan_ff[i].match_b_flag,
				wsel, pwdata[BIT_MATCH_B], arm_ff[i].b, ev_b[i]); // R1
			nxt_chan[i].match_a_flag = flag_next(chan_ff[i].match_a_flag,
				wsel, pwdata[BIT_MATCH_A], arm_ff[i].a, ev_a[i]); // R2
			nxt_chan[i].wrap_flag = flag_next(chan_ff[i].wrap_flag,
				wsel, pwdata[BIT_WRAP], arm_ff[i].w, ev_w[i]); // R3
			if (i == 1) begin
				nxt_icf = flag_next(icf_ff, wsel, pwdata[BIT_MID],
					arm_ff[i].mid, ev_cap); // R9 R10
			end
			// compare register writes
			if (wr && (paddr == cmpa_off[i])) begin
				nxt_cmp_a[i] = pwdata[CNT_W-1:0];
			end
			if (wr && (paddr == cmpb_off[i])) begin
				nxt_cmp_b[i] = pwdata[CNT_W-1:0];
			end
			// compare-A first, compare-B applied last wins
			nxt_pin[i] = out_action(ev_b[i], chan_ff[i].out_sel_b,
				out_action(ev_a[i], chan_ff[i].out_sel_a, pin_ff[i])); // R7 R8
		end
		// control and interrupt registers
		if (wr && (paddr == OFF_CTRL)) begin
			nxt_cie = pwdata[BIT_CIE];
		end
		// mask write
		if (wr && (paddr == OFF_IRQ_MASK)) begin
			nxt_imask = pwdata[IRQ_W-1:0];
		end
		// read clears only the bits that were returned
		if (rd && (paddr == OFF_IRQ_STAT)) begin
			nxt_ists = ists_ff & ~prdata_ff[IRQ_W-1:0];
		end
		// new events land even during a clearing read
		nxt_ists = nxt_ists | ev_vec; // R12
	end

	// registers only
	always_ff @(posedge pclk or negedge presetn) begin
		// asynchronous reset loads constants only
		if (!presetn) begin
			for (int i = 0; i < NCHAN; i++) begin
				chan_ff[i] <= CHAN_RESET;
				arm_ff[i] <= ARM_RESET;
				cmp_a_ff[i] <= CMP_RESET;
				cmp_b_ff[i] <= CMP_RESET;
				prev_ff[i] <= CNT_ZERO;
				pin_ff[i] <= 1'b0;
			end
			icf_ff <= 1'b0;
			cie_ff <= CIE_RESET;
			cap_ff <= CAP_WAIT_RISE;
			cap_in_prev_ff <= 1'b0;
			ists_ff <= IRQ_ZERO;
			imask_ff <= IRQ_ZERO;
			prdata_ff <= DATA_ZERO;
			pslverr_ff <= 1'b0;
		end else begin
			// load the next values
			for (int i = 0; i < NCHAN; i++) begin
				chan_ff[i] <= nxt_chan[i];
				arm_ff[i] <= nxt_arm[i];
				cmp_a_ff[i] <= nxt_cmp_a[i];
				cmp_b_ff[i] <= nxt_cmp_b[i];
				prev_ff[i] <= nxt_prev[i];
				pin_ff[i] <= nxt_pin[i];
			end
			icf_ff <= nxt_icf;
			cie_ff <= nxt_cie;
			cap_ff <= nxt_cap;
			cap_in_prev_ff <= nxt_cap_in_prev;
			ists_ff <= nxt_ists;
			imask_ff <= nxt_imask;
			prdata_ff <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end
endmodule : tsoc_top
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tsoc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0, st;
	logic [DATA_W-1:0] pwdata = '0, prdata, d;
	logic pready, pslverr, e, p, cap_in = 0, pin1, pinx, cap_req, irq;
	logic [CNT_W-1:0] cnt1 = '0, cntx = '0;
	logic [1:0] ord [4] = '{2'h2, 2'h0, 2'h1, 2'h3}; // codes, each seen
	int n_errors = 0, comparisons = 0;
	tsoc_top tsoc_top_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr,
		.chan1_counter(cnt1), .chanx_counter(cntx),
		.capture_reset_in(cap_in), .chan1_timer_out_pin(pin1),
		.chanx_timer_out_pin(pinx), .capture_irq_request(cap_req), .irq);
	// free running clock
	initial forever #2.5 pclk = ~pclk;
	// compare and count
	task chk(input string nm, input logic [31:0] got, input logic [31:0] x);
		comparisons++;
		if (got !== x) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, x, got);
		end
	endtask : chk
	// one apb transfer, result in d and e
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// wait as long as the slave needs; only the watchdog ends it
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] x, input string nm);
		apb(1'b0, a, '0);
		chk(nm, d, x);
	endtask : rd
	task wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'b1, a, v);
	endtask : wr
	// move a counter and let the event land
	task setc(input int ch, input logic [7:0] v);
		if (ch == 1) cntx <= v;
		else cnt1 <= v;
		repeat (2) @(posedge pclk);
	endtask : setc
	task cap(input logic v);
		cap_in <= v;
		repeat (3) @(posedge pclk);
	endtask : cap
	// expected pin after a match
	function automatic logic act(input logic [1:0] c, input logic q);
		case (c)
			2'h0: return q;
			2'h1: return 1'b0;
			2'h2: return 1'b1;
			default: return ~q;
		endcase
	endfunction : act
	task report_and_stop();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : report_and_stop
	// hang guard
	initial begin
		repeat (5000) @(posedge pclk);
		n_errors++;
		report_and_stop();
	end
	// main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFF_CHAN1_STAT, 32'h10, "stat1 reset");
		rd(OFF_CHANX_STAT, 32'h0, "statx reset");
		rd(OFF_CTRL, 32'h1, "ctrl reset");
		rd(OFF_CHANX_CMPB, 32'hff, "cmpb reset");
		wr(OFF_CHAN1_STAT, 32'hff);
		rd(OFF_CHAN1_STAT, 32'h1f, "ones ignored");
		for (int ch = 0; ch < 2; ch++) begin
			st = ch ? OFF_CHANX_STAT : OFF_CHAN1_STAT;
			wr(OFF_CHAN1_CMPA + 8'(8 * ch), 32'h10);
			wr(OFF_CHAN1_CMPB + 8'(8 * ch), 32'h20);
			p = 1'b0;
			for (int i = 0; i < 4; i++) begin
				wr(st, {28'h0, ord[i], ord[i]});
				setc(ch, 8'h10);
				p = act(ord[i], p);
				chk("pin a", ch ? pinx : pin1, {31'h0, p});
				setc(ch, 8'h20);
				p = act(ord[i], p);
				chk("pin b", ch ? pinx : pin1, {31'h0, p});
			end
			// zero written to flags with no read first
			wr(st, 32'h0f);
			setc(ch, 8'hff);
			setc(ch, 8'h00);
			rd(st, ch ? 32'hef : 32'hff, "flags");
			wr(st, 32'h0);
			rd(st, ch ? 32'h0 : 32'h10, "cleared");
		end
		// armed clear and a new match in one cycle: the flag stays
		setc(0, 8'h10);
		setc(0, 8'h30);
		rd(OFF_CHAN1_STAT, 32'h50, "flag a armed");
		fork
			wr(OFF_CHAN1_STAT, 32'h0);
			begin
				@(posedge pclk);
				cnt1 <= 8'h10;
			end
		join
		rd(OFF_CHAN1_STAT, 32'h50, "set wins");
		chk("irq masked", irq, 32'h0);
		rd(OFF_IRQ_STAT, 32'h3f, "irq events");
		wr(OFF_IRQ_MASK, 32'h40);
		cap(1'b1);
		rd(OFF_CHANX_STAT, 32'h0, "rise only");
		cap(1'b0);
		chk("req", cap_req, 32'h1);
		chk("irq", irq, 32'h1);
		rd(OFF_IRQ_STAT, 32'h40, "irq stat");
		chk("irq clr", irq, 32'h0);
		wr(OFF_CTRL, 32'h0);
		chk("req off", cap_req, 32'h0);
		wr(OFF_CTRL, 32'h1);
		wr(OFF_CHANX_STAT, 32'h0);
		chk("req kept", cap_req, 32'h1);
		rd(OFF_CHANX_STAT, 32'h10, "cap flag");
		wr(OFF_CHANX_STAT, 32'h0);
		chk("req clr", cap_req, 32'h0);
		apb(1'b0, 8'h24, '0);
		chk("err", {31'h0, e}, 32'h1);
		chk("err data", d, 32'h0);
		report_and_stop();
	end
endmodule : tb
`default_nettype wire

// ===== sim/tsoc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tsoc_chk
	import tsoc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tsoc_pkg::ADDR_W-1:0] paddr,
	input wire logic [tsoc_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [tsoc_pkg::CNT_W-1:0] chan1_counter,
	input wire logic [tsoc_pkg::CNT_W-1:0] chanx_counter,
	input wire logic capture_reset_in,
	input wire logic chan1_timer_out_pin,
	input wire logic chanx_timer_out_pin,
	input wire logic capture_irq_request,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// access phase and mapped address decode
	wire acc = psel && penable;
	wire bad = paddr > OFF_IRQ_MASK || paddr[1:0] != 2'h0;
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_unmapped_err: assert property (acc && bad |-> pslverr)
		else $error("no error on unmapped address");
	a_mapped_ok: assert property (acc && !bad |-> !pslverr)
		else $error("error on mapped address");
	a_rsvd_bit: assert property (acc && !pwrite && paddr == OFF_CHAN1_STAT
		|-> prdata[4] && prdata[31:8] == 24'h0)
		else $error("reserved bit not read as one");
	a_pin1_cause: assert property ($changed(chan1_timer_out_pin)
		|-> $past(chan1_counter) != $past(chan1_counter, 2))
		else $error("channel 1 pin moved without a match");
	a_pinx_cause: assert property ($changed(chanx_timer_out_pin)
		|-> $past(chanx_counter) != $past(chanx_counter, 2))
		else $error("channel x pin moved without a match");
	a_irq_drop: assert property ($fell(irq) |-> $past(acc))
		else $error("interrupt dropped without an access");
	a_req_drop: assert property ($fell(capture_irq_request)
		|-> $past(acc && pwrite))
		else $error("capture request dropped without a write");
	a_req_rise: assert property ($rose(capture_irq_request)
		|-> $past(!capture_reset_in) || $past(!capture_reset_in, 2)
		|| $past(acc && pwrite))
		else $error("capture request without a falling edge");
	c_irq: cover property ($rose(irq));
	c_req: cover property ($rose(capture_irq_request));
	c_err: cover property (acc && pslverr);
endmodule : tsoc_chk
bind tsoc_top tsoc_chk tsoc_chk_i (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .chan1_counter,
	.chanx_counter, .capture_reset_in, .chan1_timer_out_pin,
	.chanx_timer_out_pin, .capture_irq_request, .irq);
`default_nettype wire
